// ==== rtl/dac_config_serial_port.sv ====
// Configuration serial port: serial target, register file and core-side crossing
`timescale 1ns/1ps
module dac_config_serial_port #(
  parameter int REG_COUNT = dac_spi_pkg::REG_COUNT_DEF
) (
  // Core clock and reset
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_b_in,
  // Serial link
  input  wire logic                                   sclk_in,
  input  wire logic                                   cs_b_in,
  input  wire logic                                   sdio_in,
  output logic                                        sdio_data_out,
  output logic                                        sdio_oe_out,
  output logic                                        sdo_data_out,
  output logic                                        sdo_oe_out,
  // Core-side register write events
  output logic                                        reg_wr_pulse_out,
  output logic [dac_spi_pkg::ADDR_BITS-1:0]           reg_wr_addr_out,
  output logic [dac_spi_pkg::BYTE_BITS-1:0]           reg_wr_data_out,
  // Core-side applied tuning values
  output logic                                        main_load_pulse_out,
  output logic [dac_spi_pkg::TUNE_BYTES*8-1:0]        main_tuning_out,
  output logic                                        chan_load_pulse_out,
  output logic [dac_spi_pkg::TUNE_BYTES*8-1:0]        chan_tuning_out,
  // Core-side port status
  output logic                                        low_bit_leading_order_out,
  output logic                                        address_step_up_out,
  output logic                                        four_wire_out,
  output logic                                        frame_active_out
);
  import dac_spi_pkg::*;

  localparam int IDX_W    = $clog2(REG_COUNT);
  localparam int TW_W     = TUNE_BYTES * 8;
  localparam int MAIN_IDX = int'(MAIN_TUNE_ADDR);
  localparam int CHAN_IDX = int'(CHAN_TUNE_ADDR);

  if (REG_COUNT < REG_COUNT_MIN || REG_COUNT > (1 << ADDR_BITS)) begin : g_bad_depth
    $error("REG_COUNT must cover the tuning registers and fit the address space");
  end

  // ---------------- Serial clock domain ----------------
  logic [7:0]           regs_ff [REG_COUNT];
  ser_state_t           state_ff;
  ser_state_t           nxt_state;
  logic [3:0]           cnt_ff;
  logic [3:0]           nxt_cnt;
  logic [15:0]          instr_ff;
  logic [15:0]          nxt_instr;
  logic [7:0]           byte_ff;
  logic [7:0]           nxt_byte;
  logic [14:0]          addr_ff;
  logic [14:0]          nxt_addr;
  logic                 rw_ff;
  logic                 sdo_ff;
  logic                 drive_ff;
  logic [14:0]          wr_addr_ff;
  logic [7:0]           wr_data_ff;
  logic                 wr_tgl_ff;
  logic                 main_tgl_ff;
  logic                 chan_tgl_ff;
  logic [TW_W-1:0]      main_act_ff;
  logic [TW_W-1:0]      chan_act_ff;
  logic [TW_W-1:0]      main_pend;
  logic [TW_W-1:0]      chan_pend;

  // Frame sequencing and read launch are cleared whenever select is high; register file and toggles are not
  wire              ser_rst_b   = rst_b_in & ~cs_b_in;
  wire [7:0]        cfg         = regs_ff[0];
  wire              lsb_first   = cfg[CFG_LSB_FIRST_HI] | cfg[CFG_LSB_FIRST_LO];
  wire              step_up     = cfg[CFG_STEP_UP_HI] | cfg[CFG_STEP_UP_LO];
  wire              four_wire   = cfg[CFG_FOUR_WIRE_HI] | cfg[CFG_FOUR_WIRE_LO];
  wire              in_instr    = (state_ff == ST_INSTR);
  wire              in_data     = (state_ff == ST_DATA);
  wire              instr_done  = in_instr && (cnt_ff == 4'hF);
  wire              byte_done   = in_data && (cnt_ff[2:0] == 3'h7);
  wire              addr_hit    = ({17'h00000, addr_ff} < REG_COUNT);
  wire [IDX_W-1:0]  idx         = addr_ff[IDX_W-1:0];
  wire              wr_fire     = byte_done && !rw_ff && addr_hit;
  wire              load_fire   = wr_fire && (addr_ff == LOAD_REQ_ADDR);
  wire              main_go     = load_fire && nxt_byte[MAIN_LOAD_BIT];
  wire              chan_go     = load_fire && nxt_byte[CHAN_LOAD_BIT];
  wire              soft_rst    = wr_fire && (addr_ff == CFG_ADDR) &&
                                  (nxt_byte[CFG_SOFT_RST_HI] | nxt_byte[CFG_SOFT_RST_LO]);
  wire [14:0]       addr_up     = addr_ff + 15'h0001;
  wire [14:0]       addr_down   = addr_ff - 15'h0001;
  wire [14:0]       step_addr   = step_up ? addr_up : addr_down;
  wire [7:0]        rd_byte     = addr_hit ? regs_ff[idx] : 8'h00;
  wire [2:0]        bit_idx     = lsb_first ? cnt_ff[2:0] : (3'h7 - cnt_ff[2:0]);

  // Both orders leave direction in bit 15 and A0 in bit 0
  assign nxt_instr = lsb_first ? {sdio_in, instr_ff[15:1]} : {instr_ff[14:0], sdio_in};
  assign nxt_byte  = lsb_first ? {sdio_in, byte_ff[7:1]} : {byte_ff[6:0], sdio_in};
  assign nxt_cnt   = cnt_ff + 4'h1;
  assign nxt_addr  = instr_done ? nxt_instr[ADDR_BITS-1:0] :
                     byte_done  ? step_addr : addr_ff;

  // Instruction phase hands over to the data phase after the sixteenth bit
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_INSTR: begin
        if (instr_done) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        nxt_state = ST_DATA;
      end
      default: begin
        nxt_state = ST_INSTR;
      end
    endcase
  end

  // Bit sampling and frame sequencing
  always_ff @(posedge sclk_in or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      state_ff <= ST_INSTR;
      cnt_ff   <= 4'h0;
      instr_ff <= 16'h0000;
      byte_ff  <= 8'h00;
      addr_ff  <= 15'h0000;
      rw_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      instr_ff <= in_instr ? nxt_instr : instr_ff;
      byte_ff  <= in_data ? nxt_byte : byte_ff;
      addr_ff  <= nxt_addr;
      if (instr_done) begin
        rw_ff <= nxt_instr[RW_BIT];
      end
    end
  end

  // Register file, written as each byte completes
  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= REG_RESET;
      end
      regs_ff[0] <= CFG_RESET;
    end else if (soft_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= REG_RESET;
      end
      regs_ff[0] <= CFG_RESET;
    end else if (wr_fire) begin
      regs_ff[idx] <= nxt_byte;
    end
  end

  for (genvar g = 0; g < TUNE_BYTES; g++) begin : g_pend
    assign main_pend[g*8 +: 8] = regs_ff[MAIN_IDX + g];
    assign chan_pend[g*8 +: 8] = regs_ff[CHAN_IDX + g];
  end

  // Write events, announced to the core by a toggle
  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_addr_ff <= 15'h0000;
      wr_data_ff <= 8'h00;
      wr_tgl_ff  <= 1'b0;
    end else if (wr_fire) begin
      wr_addr_ff <= addr_ff;
      wr_data_ff <= nxt_byte;
      wr_tgl_ff  <= ~wr_tgl_ff;
    end
  end

  // Tuning loads: the pending group is copied and announced by a toggle
  always_ff @(posedge sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      main_tgl_ff <= 1'b0;
      chan_tgl_ff <= 1'b0;
      main_act_ff <= '0;
      chan_act_ff <= '0;
    end else begin
      if (main_go) begin
        main_act_ff <= main_pend;
        main_tgl_ff <= ~main_tgl_ff;
      end
      if (chan_go) begin
        chan_act_ff <= chan_pend;
        chan_tgl_ff <= ~chan_tgl_ff;
      end
    end
  end

  // Read data launched on the falling edge for capture on the next rise
  always_ff @(negedge sclk_in or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      sdo_ff   <= 1'b0;
      drive_ff <= 1'b0;
    end else begin
      sdo_ff   <= rd_byte[bit_idx];
      drive_ff <= in_data && rw_ff;
    end
  end

  assign sdio_data_out = sdo_ff;
  assign sdio_oe_out   = drive_ff & ~four_wire;
  assign sdo_data_out  = sdo_ff;
  assign sdo_oe_out    = drive_ff & four_wire;

  // ---------------- Core clock domain ----------------
  logic [XING_BITS-1:0] xing_sync;
  logic                 sel_sync;
  logic [2:0]           tgl_seen_ff;
  logic                 wr_pulse_ff;
  logic                 main_pulse_ff;
  logic                 chan_pulse_ff;
  logic [14:0]          core_addr_ff;
  logic [7:0]           core_data_ff;
  logic [TW_W-1:0]      main_tune_ff;
  logic [TW_W-1:0]      chan_tune_ff;

  // Toggles and configuration levels; each bit is an independent level
  dac_spi_sync #(
    .WIDTH    (XING_BITS)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in ({four_wire, step_up, lsb_first, chan_tgl_ff, main_tgl_ff, wr_tgl_ff}),
    .sync_out (xing_sync)
  );

  // Select level for the frame status
  dac_spi_sync #(
    .WIDTH    (1)
  ) u_sync_sel (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in (~cs_b_in),
    .sync_out (sel_sync)
  );

  wire [2:0] tgl_edge = xing_sync[2:0] ^ tgl_seen_ff;

  // One pulse per toggle change
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tgl_seen_ff   <= 3'h0;
      wr_pulse_ff   <= 1'b0;
      main_pulse_ff <= 1'b0;
      chan_pulse_ff <= 1'b0;
    end else begin
      tgl_seen_ff   <= xing_sync[2:0];
      wr_pulse_ff   <= tgl_edge[0];
      main_pulse_ff <= tgl_edge[1];
      chan_pulse_ff <= tgl_edge[2];
    end
  end

  // Serial side holds these values still until its next event
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      core_addr_ff  <= 15'h0000;
      core_data_ff  <= 8'h00;
      main_tune_ff  <= '0;
      chan_tune_ff  <= '0;
    end else begin
      if (tgl_edge[0]) begin
        core_addr_ff <= wr_addr_ff;
        core_data_ff <= wr_data_ff;
      end
      if (tgl_edge[1]) begin
        main_tune_ff <= main_act_ff;
      end
      if (tgl_edge[2]) begin
        chan_tune_ff <= chan_act_ff;
      end
    end
  end

  assign reg_wr_pulse_out          = wr_pulse_ff;
  assign reg_wr_addr_out           = core_addr_ff;
  assign reg_wr_data_out           = core_data_ff;
  assign main_load_pulse_out       = main_pulse_ff;
  assign main_tuning_out           = main_tune_ff;
  assign chan_load_pulse_out       = chan_pulse_ff;
  assign chan_tuning_out           = chan_tune_ff;
  assign low_bit_leading_order_out = xing_sync[3];
  assign address_step_up_out       = xing_sync[4];
  assign four_wire_out             = xing_sync[5];
  assign frame_active_out          = sel_sync;

endmodule : dac_config_serial_port

// ==== rtl/dac_spi_pkg.sv ====
// Constants and types shared by the configuration serial port
package dac_spi_pkg;

  // Frame layout
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS  = 8;
  localparam int ADDR_BITS  = 15;
  localparam int RW_BIT     = 15;

  // Port configuration register and its mirrored field pairs
  localparam logic [14:0] CFG_ADDR         = 15'h0000;
  localparam int          CFG_SOFT_RST_HI  = 7;
  localparam int          CFG_LSB_FIRST_HI = 6;
  localparam int          CFG_STEP_UP_HI   = 5;
  localparam int          CFG_FOUR_WIRE_HI = 4;
  localparam int          CFG_FOUR_WIRE_LO = 3;
  localparam int          CFG_STEP_UP_LO   = 2;
  localparam int          CFG_LSB_FIRST_LO = 1;
  localparam int          CFG_SOFT_RST_LO  = 0;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [7:0]  REG_RESET        = 8'h00;

  // Tuning groups: tuning word bytes followed by phase offset bytes
  localparam logic [14:0] MAIN_TUNE_ADDR = 15'h0010;
  localparam logic [14:0] CHAN_TUNE_ADDR = 15'h0018;
  localparam logic [14:0] LOAD_REQ_ADDR  = 15'h001F;
  localparam int          MAIN_LOAD_BIT  = 0;
  localparam int          CHAN_LOAD_BIT  = 1;
  localparam int          TUNE_BYTES     = 8;

  // Register file depth and link limit
  localparam int REG_COUNT_DEF = 64;
  localparam int REG_COUNT_MIN = 32;
  localparam int SCLK_MAX_MHZ  = 80;

  // Crossing toggles and levels
  localparam int XING_BITS = 6;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10
  } ser_state_t;

endpackage : dac_spi_pkg

// ==== rtl/dac_spi_sync.sv ====
// Two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module dac_spi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // Levels from another domain and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff   <= '0;
      stable_ff <= '0;
    end else begin
      meta_ff   <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule : dac_spi_sync

// ==== verification/dac_config_serial_port_asserts.sv ====
// Concurrent checks on the configuration serial port boundary
`timescale 1ns/1ps
module dac_config_serial_port_asserts #(
  parameter int REG_COUNT = 64
) (
  // Clocks, reset and select
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        sclk_in,
  input wire logic        cs_b_in,
  // Pin drivers
  input wire logic        sdio_oe_out,
  input wire logic        sdo_oe_out,
  // Core side
  input wire logic        reg_wr_pulse_out,
  input wire logic [14:0] reg_wr_addr_out,
  input wire logic [7:0]  reg_wr_data_out,
  input wire logic        main_load_pulse_out,
  input wire logic [63:0] main_tuning_out,
  input wire logic        chan_load_pulse_out,
  input wire logic [63:0] chan_tuning_out,
  input wire logic        four_wire_out,
  input wire logic        frame_active_out
);
  // Rising serial edges seen in the current frame
  logic [4:0] rise_cnt_ff;

  always_ff @(posedge sclk_in or posedge cs_b_in) begin
    if (cs_b_in) begin
      rise_cnt_ff <= 5'h00;
    end else if (rise_cnt_ff != 5'h1F) begin
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
  end

  a_oe_select_high: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cs_b_in |-> !sdio_oe_out && !sdo_oe_out) else $error("pin driven while deselected");
  a_oe_one_pin: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(sdio_oe_out && sdo_oe_out)) else $error("both data pins driven");
  a_oe_pin_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sdio_oe_out || sdo_oe_out) |-> sdo_oe_out == four_wire_out) else $error("read on wrong pin");
  a_oe_after_instr: assert property (@(posedge sclk_in) disable iff (cs_b_in)
    rise_cnt_ff < 5'h10 |-> !sdio_oe_out && !sdo_oe_out) else $error("driven during instruction");
  a_wr_pulse_once: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_wr_pulse_out |=> !reg_wr_pulse_out) else $error("write pulse too long");
  a_wr_value_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !reg_wr_pulse_out |-> $stable({reg_wr_addr_out, reg_wr_data_out})) else $error("write event moved");
  a_wr_addr_range: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_wr_pulse_out |-> reg_wr_addr_out < REG_COUNT) else $error("write beyond register file");
  a_main_tune_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !main_load_pulse_out |-> $stable(main_tuning_out)) else $error("main tuning without load");
  a_chan_tune_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !chan_load_pulse_out |-> $stable(chan_tuning_out)) else $error("channel tuning without load");
  a_frame_start: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(cs_b_in) |-> ##[1:4] frame_active_out) else $error("frame start not seen");
  a_frame_end: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(cs_b_in) |-> ##[1:4] !frame_active_out) else $error("frame end not seen");

  c_write: cover property (@(posedge clk_in) reg_wr_pulse_out);
  c_main: cover property (@(posedge clk_in) main_load_pulse_out);
  c_chan: cover property (@(posedge clk_in) chan_load_pulse_out);
  c_sdo: cover property (@(posedge clk_in) sdo_oe_out);
endmodule : dac_config_serial_port_asserts

// ==== verification/dac_spi_host.sv ====
// Host controller model driving the serial configuration link
`timescale 1ns/1ps
module dac_spi_host (
  // Lines driven by the host
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      sd_out,
  // Read data as seen by the host
  input wire logic  sdio_in,
  input wire logic  sdo_in,
  input wire logic  sdo_oe_in
);
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    sd_out   = 1'b0;
  end

  // Sends nbits of a frame; a short count aborts it in mid-frame
  task automatic frame(input bit lsb, input logic [15:0] instr, input logic [63:0] wdat,
                       input int nbits, output logic [63:0] rdat);
    int k;
    int b;
    rdat = '0;
    #37;
    cs_b_out = 1'b0;
    for (k = 0; k < nbits; k++) begin
      b = (k < 16) ? k : (k - 16) % 8;
      if (k < 16)
        sd_out = lsb ? instr[b] : instr[15-b];
      else if (instr[15])
        sd_out = ~sd_out; // Released line toggles rather than holding a value
      else
        sd_out = wdat[(k-16)/8*8 + (lsb ? b : 7-b)];
      #80;
      sclk_out = 1'b1;
      if (k >= 16)
        rdat[(k-16)/8*8 + (lsb ? b : 7-b)] = sdo_oe_in ? sdo_in : sdio_in;
      #80;
      sclk_out = 1'b0;
    end
    #80;
    cs_b_out = 1'b1;
  endtask : frame
endmodule : dac_spi_host

// ==== verification/dac_config_serial_port_tb.sv ====
// Self-checking bench for the configuration serial port
`timescale 1ns/1ps
module dac_config_serial_port_tb;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        sclk_in, cs_b_in, host_sd, sdio_in;
  logic        sdio_data_out, sdio_oe_out, sdo_data_out, sdo_oe_out, reg_wr_pulse_out;
  logic [14:0] reg_wr_addr_out;
  logic [7:0]  reg_wr_data_out;
  logic        main_load_pulse_out, chan_load_pulse_out, frame_active_out;
  logic [63:0] main_tuning_out, chan_tuning_out, rd;
  logic        low_bit_leading_order_out, address_step_up_out, four_wire_out;
  logic [22:0] wq[$];
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_main = 0;
  int          n_chan = 0;

  always #12.5 clk_in = ~clk_in;
  assign sdio_in = sdio_oe_out ? sdio_data_out : host_sd;

  dac_config_serial_port #(.REG_COUNT(64)) dut (.clk_in, .rst_b_in, .sclk_in, .cs_b_in, .sdio_in,
    .sdio_data_out, .sdio_oe_out, .sdo_data_out, .sdo_oe_out, .reg_wr_pulse_out, .reg_wr_addr_out,
    .reg_wr_data_out, .main_load_pulse_out, .main_tuning_out, .chan_load_pulse_out, .chan_tuning_out,
    .low_bit_leading_order_out, .address_step_up_out, .four_wire_out, .frame_active_out);
  dac_spi_host host (.sclk_out(sclk_in), .cs_b_out(cs_b_in), .sd_out(host_sd), .sdio_in(sdio_in),
    .sdo_in(sdo_data_out), .sdo_oe_in(sdo_oe_out));

  always @(negedge clk_in) begin
    if (reg_wr_pulse_out === 1'b1) wq.push_back({reg_wr_addr_out, reg_wr_data_out});
    if (main_load_pulse_out === 1'b1) n_main++;
    if (chan_load_pulse_out === 1'b1) n_chan++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_wr(input int n);
    for (int i = 0; i < 200 && wq.size() < n; i++) @(posedge clk_in);
  endtask : wait_wr

  task automatic s_write_down();
    wq.delete();
    host.frame(0, 16'h0005, 64'hC3B2A1, 40, rd);
    wait_wr(3);
    chk(wq.size(), 3);
    chk(wq[0], {15'h0005, 8'hA1});
    chk(wq[1], {15'h0004, 8'hB2});
    chk(wq[2], {15'h0003, 8'hC3});
  endtask : s_write_down

  task automatic s_read_back(input bit lsb, input logic [14:0] a, input logic [15:0] exp);
    wq.delete();
    host.frame(lsb, {1'b1, a}, 64'h0, 32, rd);
    chk(rd[15:0], exp);
    repeat (8) @(posedge clk_in);
    chk(wq.size(), 0);
  endtask : s_read_back

  task automatic s_config_lsb();
    wq.delete();
    host.frame(0, 16'h0000, 64'h7E, 24, rd);
    wait_wr(1);
    repeat (4) @(posedge clk_in);
    chk({low_bit_leading_order_out, address_step_up_out, four_wire_out}, 3'h7);
    wq.delete();
    host.frame(1, 16'h0008, 64'h2211, 32, rd);
    wait_wr(2);
    chk(wq[0], {15'h0008, 8'h11});
    chk(wq[1], {15'h0009, 8'h22});
  endtask : s_config_lsb

  task automatic s_tuning();
    wq.delete();
    host.frame(1, 16'h0010, 64'h0807060504030201, 80, rd);
    wait_wr(8);
    chk(main_tuning_out, 64'h0);
    host.frame(1, 16'h001F, 64'h01, 24, rd);
    wait_wr(9);
    repeat (4) @(posedge clk_in);
    chk(main_tuning_out, 64'h0807060504030201);
    chk(n_main, 1);
    chk(n_chan, 0);
    host.frame(1, 16'h0018, 64'h5A, 24, rd);
    wait_wr(10);
    chk(chan_tuning_out, 64'h0);
    host.frame(1, 16'h001F, 64'h02, 24, rd);
    wait_wr(11);
    repeat (4) @(posedge clk_in);
    chk(chan_tuning_out[7:0], 8'h5A);
    chk(n_chan, 1);
    chk(n_main, 1);
  endtask : s_tuning

  task automatic s_abort();
    wq.delete();
    host.frame(1, 16'h0007, 64'hFF, 12, rd);
    host.frame(1, 16'h0006, 64'hFF, 20, rd);
    host.frame(1, 16'h0006, 64'h77, 24, rd);
    wait_wr(1);
    repeat (8) @(posedge clk_in);
    chk(wq.size(), 1);
    chk(wq[0], {15'h0006, 8'h77});
    chk(frame_active_out, 1'b0);
  endtask : s_abort

  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    s_write_down();
    s_read_back(0, 15'h0005, 16'hB2A1);
    s_config_lsb();
    s_read_back(1, 15'h0008, 16'h2211);
    s_tuning();
    s_abort();
    tally_and_finish();
  end
endmodule : dac_config_serial_port_tb

bind dac_config_serial_port dac_config_serial_port_asserts #(.REG_COUNT(REG_COUNT)) u_chk (.clk_in, .rst_b_in,
  .sclk_in, .cs_b_in, .sdio_oe_out, .sdo_oe_out, .reg_wr_pulse_out, .reg_wr_addr_out, .reg_wr_data_out,
  .main_load_pulse_out, .main_tuning_out, .chan_load_pulse_out, .chan_tuning_out, .four_wire_out,
  .frame_active_out);
